// ==== rtl/cds_pkg.sv ====
// Package: register map, fields and types of the channel divider sync block
`default_nettype none

package cds_pkg;

    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [11:0] IDX_IOUPD = 12'h00F;
    localparam logic [11:0] IDX_STATUS = 12'h010;
    localparam logic [11:0] IDX_FRAC = 12'h100;
    localparam logic [11:0] IDX_VCO = 12'h120;
    localparam logic [11:0] IDX_MASK = 12'h122;
    localparam logic [11:0] IDX_INT = 12'h200;
    // Per divider: group0..group4, feedback
    localparam logic [71:0] IDX_RATIO = {12'h110, 12'h244, 12'h240, 12'h14A, 12'h146, 12'h140};
    localparam logic [71:0] IDX_PHASE = {12'h111, 12'h245, 12'h241, 12'h14B, 12'h147, 12'h141};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_RST_A = 0;
    localparam int B_PD_A = 1;
    localparam int B_SYN_A = 2;
    localparam int B_RST_B = 4;
    localparam int B_PD_B = 5;
    localparam int B_SYN_B = 6;
    localparam int B_LOOP_RST = 0;
    localparam int B_LOOP_SYN = 2;
    localparam int B_SRC = 6;
    localparam int B_OSRC = 7;
    localparam int M_A_G0 = 0;
    localparam int M_A_G1 = 1;
    localparam int M_A_G2 = 2;
    localparam int M_A_G3 = 3;
    localparam int M_A_FB = 4;
    localparam int M_B_G1 = 5;
    localparam int M_B_G2 = 6;

    // ****************************************
    // Values and reset values
    // ****************************************
    localparam int DIV_N = 6;
    localparam logic [7:0] IOUPD_GO = 8'h01;
    localparam logic [5:0] RATIO_RST = 6'h04;
    localparam logic [5:0] RATIO_FB_RST = 6'h01;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] PHASE_RST = 8'h00;

    typedef enum logic [1:0] {
        SRC_A = 2'b00,
        SRC_B = 2'b01,
        SRC_INT = 2'b10
    } cds_src_t;

endpackage

`default_nettype wire

// ==== rtl/cds_top.sv ====
// Channel divider source selection, sync domains and output driver sources
//
// Function
// - group0 and feedback dividers always clock from vco_divider_a.
// - group1/group2 source bit 6: 0 picks vco_divider_a, 1 picks vco_divider_b.
// - group3 source bit 6: 0 picks int_loop output, 1 picks vco_divider_a.
// - group4 divider always clocks from int_loop output.
// - Sync high holds a divider at its initial phase; low lets it count.
// - Dividers released together start aligned; alignment repeats at the GCD rate.
// - Four sync domains by source: a, b, int_loop, frac_loop covering a and b.
// - Manual sync bits: 0x120 bits 2 and 6, 0x100 bit 2, 0x200 bit 2.
// - Effective domain sync is manual bit OR automatic sync pulses.
// - vco_divider_a reset or power-down release syncs the a domain.
// - vco_divider_b reset or power-down release syncs the b domain.
// - First calibration after reset or frac_loop reset release syncs frac_loop domain.
// - int_loop reset bit release syncs the int_loop domain.
// - Mask bits in 0x122 block a domain's sync per divider; a mask blocks frac_loop.
// - Groups 0 to 2 drivers take only their own divider output.
// - Pair eight/nine source: 0 group3 divider, 1 int_loop input reference.
// - Reference-sourced group is gated off on loss of reference.
// - driver_ten source: 0 group4 divider, 1 int_loop input reference.
// - int_loop power-down asserts when no driver eight, nine or ten uses it.
// - Divide ratio 1 to 64 from a 6-bit field.
// - Initial phase 0 to 63 half input periods, applied at sync release.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module cds_top import cds_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Source clock edges, one pulse per half period
    input wire logic vco_a_edge,
    input wire logic vco_b_edge,
    input wire logic int_edge,
    // int_loop active input reference and loop events
    input wire logic ref_clk,
    input wire logic ref_lost,
    input wire logic cal_done,
    // Driver sources
    output logic group0_out,
    output logic group1_out,
    output logic group2_out,
    output logic pair_eight_nine_out,
    output logic driver_ten_out,
    output logic feedback_out,
    output logic int_loop_pd
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic [11:0] idx_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_word;

    // Address phase accepted while the bus is ready
    wire take = hsel & htrans[1] & hready;
    wire [7:0] wd = hwdata[7:0];
    wire wr_frac = wr_pend_r & (idx_r == IDX_FRAC);
    wire wr_vco = wr_pend_r & (idx_r == IDX_VCO);
    wire wr_mask = wr_pend_r & (idx_r == IDX_MASK);
    wire wr_int = wr_pend_r & (idx_r == IDX_INT);
    // Writing the go value to the update index copies every shadow
    wire io_update = wr_pend_r & (idx_r == IDX_IOUPD) & (wd == IOUPD_GO);

    function automatic logic hit(input logic [11:0] idx, input logic [71:0] tbl, input int i);
        hit = (idx == tbl[i*12 +: 12]);
    endfunction

    // Reads take one wait cycle so hrdata comes from a flip-flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx_r <= 12'h000;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
        end else begin
            if (take) begin
                idx_r <= haddr[13:2];
            end
            wr_pend_r <= take & hwrite;
            rd_pend_r <= take & ~hwrite;
            hreadyout_r <= ~(take & ~hwrite);
            if (rd_pend_r) begin
                hrdata_r <= rd_word;
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;

    // ****************************************
    // Shadow and active registers
    // ****************************************
    // Bus-side shadows; readback returns these, not the active copies
    logic [7:0] frac_s;
    logic [7:0] vco_s;
    logic [7:0] mask_s;
    logic [7:0] int_s;
    logic [5:0] ratio_s [DIV_N];
    logic [7:0] phase_s [DIV_N];
    logic [7:0] frac_a;
    logic [7:0] vco_a;
    logic [7:0] mask_a;
    logic [7:0] int_a;
    logic [5:0] ratio_a [DIV_N];
    logic [7:0] phase_a [DIV_N];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frac_s <= CTL_RST;
            vco_s <= CTL_RST;
            mask_s <= CTL_RST;
            int_s <= CTL_RST;
            for (int i = 0; i < DIV_N; i++) begin
                ratio_s[i] <= (i == DIV_N - 1) ? RATIO_FB_RST : RATIO_RST;
                phase_s[i] <= PHASE_RST;
            end
        end else begin
            // Only the low byte of each word is stored
            if (wr_frac) begin
                frac_s <= wd;
            end
            if (wr_vco) begin
                vco_s <= wd;
            end
            if (wr_mask) begin
                mask_s <= wd;
            end
            if (wr_int) begin
                int_s <= wd;
            end
            for (int i = 0; i < DIV_N; i++) begin
                if (wr_pend_r && hit(idx_r, IDX_RATIO, i)) begin
                    ratio_s[i] <= wd[5:0];
                end
                if (wr_pend_r && hit(idx_r, IDX_PHASE, i)) begin
                    phase_s[i] <= wd;
                end
            end
        end
    end

    // Active copies follow the shadows only at an I/O update
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frac_a <= CTL_RST;
            vco_a <= CTL_RST;
            mask_a <= CTL_RST;
            int_a <= CTL_RST;
            for (int i = 0; i < DIV_N; i++) begin
                ratio_a[i] <= (i == DIV_N - 1) ? RATIO_FB_RST : RATIO_RST;
                phase_a[i] <= PHASE_RST;
            end
        end else if (io_update) begin
            frac_a <= frac_s;
            vco_a <= vco_s;
            mask_a <= mask_s;
            int_a <= int_s;
            for (int i = 0; i < DIV_N; i++) begin
                ratio_a[i] <= ratio_s[i];
                phase_a[i] <= phase_s[i];
            end
        end
    end

    // ****************************************
    // Automatic sync sources
    // ****************************************
    // Previous active values, for one-cycle release pulses
    logic [7:0] vco_p_r;
    logic frac_rst_p_r;
    logic int_rst_p_r;
    logic cal_armed_r;

    wire auto_a = (vco_p_r[B_RST_A] & ~vco_a[B_RST_A])
                | (vco_p_r[B_PD_A] & ~vco_a[B_PD_A]);
    wire auto_b = (vco_p_r[B_RST_B] & ~vco_a[B_RST_B])
                | (vco_p_r[B_PD_B] & ~vco_a[B_PD_B]);
    wire auto_i = int_rst_p_r & ~int_a[B_LOOP_RST];
    wire frac_rst_fall = frac_rst_p_r & ~frac_a[B_LOOP_RST];
    wire auto_f = cal_armed_r & cal_done;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vco_p_r <= CTL_RST;
            frac_rst_p_r <= 1'b0;
            int_rst_p_r <= 1'b0;
            cal_armed_r <= 1'b1;
        end else begin
            vco_p_r <= vco_a;
            frac_rst_p_r <= frac_a[B_LOOP_RST];
            int_rst_p_r <= int_a[B_LOOP_RST];
            // Rearm on frac_loop reset release wins over a coinciding calibration end
            cal_armed_r <= (cal_armed_r & ~cal_done) | frac_rst_fall;
        end
    end

    // ****************************************
    // Sync domains
    // ****************************************
    // frac_loop sync reaches both post-divider domains
    wire sync_f = frac_a[B_LOOP_SYN] | auto_f;
    wire sync_da = vco_a[B_SYN_A] | auto_a | sync_f;
    wire sync_db = vco_a[B_SYN_B] | auto_b | sync_f;
    wire sync_di = int_a[B_LOOP_SYN] | auto_i;

    cds_src_t src [DIV_N];
    logic [DIV_N-1:0] msk_a;
    logic [DIV_N-1:0] msk_b;
    logic [DIV_N-1:0] dsync;
    logic [DIV_N-1:0] tick;

    // Input source of each divider
    assign src[0] = SRC_A;
    assign src[1] = phase_a[1][B_SRC] ? SRC_B : SRC_A;
    assign src[2] = phase_a[2][B_SRC] ? SRC_B : SRC_A;
    assign src[3] = phase_a[3][B_SRC] ? SRC_A : SRC_INT;
    assign src[4] = SRC_INT;
    assign src[5] = SRC_A;

    assign msk_a = {mask_a[M_A_FB], 1'b0, mask_a[M_A_G3], mask_a[M_A_G2],
                    mask_a[M_A_G1], mask_a[M_A_G0]};
    assign msk_b = {3'b000, mask_a[M_B_G2], mask_a[M_B_G1], 1'b0};

    for (genvar g = 0; g < DIV_N; g++) begin : g_sel
        // Mask on domain a also blocks frac_loop sync
        assign dsync[g] = (src[g] == SRC_A) ? (sync_da & ~msk_a[g]) :
                          (src[g] == SRC_B) ? (sync_db & ~msk_b[g]) :
                          sync_di;
        // Each divider counts edges of its own source
        assign tick[g] = (src[g] == SRC_A) ? vco_a_edge :
                         (src[g] == SRC_B) ? vco_b_edge :
                         int_edge;
    end

    // ****************************************
    // Channel dividers
    // ****************************************
    logic [5:0] cnt_r [DIV_N];
    logic [5:0] dly_r [DIV_N];
    logic [DIV_N-1:0] div_out_r;

    // Ratio field 0 wraps to a last count of 63, dividing by 64
    // Sync clears count and output and loads the phase delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_out_r <= '0;
            for (int i = 0; i < DIV_N; i++) begin
                cnt_r[i] <= 6'h00;
                dly_r[i] <= 6'h00;
            end
        end else begin
            for (int i = 0; i < DIV_N; i++) begin
                if (dsync[i]) begin
                    cnt_r[i] <= 6'h00;
                    dly_r[i] <= phase_a[i][5:0];
                    div_out_r[i] <= 1'b0;
                end else if (tick[i]) begin
                    // Phase delay runs out before the first toggle
                    if (dly_r[i] != 6'h00) begin
                        dly_r[i] <= dly_r[i] - 6'h01;
                    end else if (cnt_r[i] == 6'(ratio_a[i] - 6'h01)) begin
                        cnt_r[i] <= 6'h00;
                        div_out_r[i] <= ~div_out_r[i];
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 6'h01;
                    end
                end
            end
        end
    end

    // ****************************************
    // Output driver sources
    // ****************************************
    logic group0_r;
    logic group1_r;
    logic group2_r;
    logic pair_r;
    logic ten_r;
    logic fb_r;
    logic int_pd_r;

    wire pair_eight_nine_source_select = phase_a[3][B_OSRC];
    wire ten_sel = phase_a[4][B_SRC];
    // Selected reference is forced low while it is lost
    wire ref_gated = ref_clk & ~ref_lost;
    wire pair_nxt = pair_eight_nine_source_select ? ref_gated : div_out_r[3];
    wire ten_nxt = ten_sel ? ref_gated : div_out_r[4];
    // int_loop output is used only through group3 or group4
    wire pair_uses_int = ~pair_eight_nine_source_select & (src[3] == SRC_INT);
    wire ten_uses_int = ~ten_sel;
    wire int_used = pair_uses_int | ten_uses_int;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            group0_r <= 1'b0;
            group1_r <= 1'b0;
            group2_r <= 1'b0;
            pair_r <= 1'b0;
            ten_r <= 1'b0;
            fb_r <= 1'b0;
            int_pd_r <= 1'b0;
        end else begin
            group0_r <= div_out_r[0];
            group1_r <= div_out_r[1];
            group2_r <= div_out_r[2];
            pair_r <= pair_nxt;
            ten_r <= ten_nxt;
            fb_r <= div_out_r[5];
            int_pd_r <= ~int_used;
        end
    end

    assign group0_out = group0_r;
    assign group1_out = group1_r;
    assign group2_out = group2_r;
    assign pair_eight_nine_out = pair_r;
    assign driver_ten_out = ten_r;
    assign feedback_out = fb_r;
    assign int_loop_pd = int_pd_r;

    // ****************************************
    // Read data selection
    // ****************************************
    // Status: armed flag, int_loop power-down, reference loss, per-divider sync
    wire [8:0] status_word = {cal_armed_r, int_pd_r, ref_lost, dsync};

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (idx_r)
            IDX_FRAC: rd_word[7:0] = frac_s;
            IDX_VCO: rd_word[7:0] = vco_s;
            IDX_MASK: rd_word[7:0] = mask_s;
            IDX_INT: rd_word[7:0] = int_s;
            IDX_STATUS: rd_word[8:0] = status_word;
            default: rd_word = 32'h0000_0000;
        endcase
        for (int i = 0; i < DIV_N; i++) begin
            if (hit(idx_r, IDX_RATIO, i)) begin
                rd_word[5:0] = ratio_s[i];
            end
            if (hit(idx_r, IDX_PHASE, i)) begin
                rd_word[7:0] = phase_s[i];
            end
        end
    end

    // Inputs a word-only slave leaves unused
    wire unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[31:14], haddr[1:0]};

endmodule

`default_nettype wire

// ==== tb/cds_monitor.sv ====
// Port checker for the channel divider sync block
`timescale 1ns/10ps
`default_nettype none

module cds_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Sources and outputs
    input wire logic vco_a_edge,
    input wire logic vco_b_edge,
    input wire logic int_edge,
    input wire logic ref_clk,
    input wire logic group0_out,
    input wire logic group1_out,
    input wire logic feedback_out,
    input wire logic driver_ten_out,
    input wire logic int_loop_pd
);
    // ****
    // Bus timing
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire req = hsel && htrans[1] && hready;

    hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
    rd_wait_a: assert property (req && !hwrite |=> !hreadyout) else $error("no read wait");
    wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    wr_nowait_a: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
    rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    rdata_upper_a: assert property (hrdata[31:9] == 23'h0) else $error("upper bits set");

    // ****
    // Divider sources
    // ****
    g0_src_a: assert property ($rose(group0_out) |-> $past(vco_a_edge, 2))
        else $error("group0 rose without a edge");
    fb_src_a: assert property ($rose(feedback_out) |-> $past(vco_a_edge, 2))
        else $error("feedback rose without a edge");
    g1_src_a: assert property ($rose(group1_out) |-> $past(vco_a_edge | vco_b_edge, 2))
        else $error("group1 rose without edge");
    ten_src_a: assert property ($rose(driver_ten_out) |->
        $past(int_edge | ref_clk) || $past(int_edge | ref_clk, 2)
        || $past(int_edge | ref_clk, 3)) else $error("driver ten rose without source");

    cover property (req && !hwrite);
    cover property ($rose(int_loop_pd));
    cover property ($rose(driver_ten_out));
endmodule

bind cds_top cds_monitor u_mon (.clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .vco_a_edge(vco_a_edge), .vco_b_edge(vco_b_edge),
    .int_edge(int_edge), .ref_clk(ref_clk), .group0_out(group0_out),
    .group1_out(group1_out), .feedback_out(feedback_out),
    .driver_ten_out(driver_ten_out), .int_loop_pd(int_loop_pd));
`default_nettype wire

// ==== tb/test_channel_divider_source_sync.sv ====
// Self-checking testbench of the channel divider sync block
`timescale 1ns/10ps
`default_nettype none

module test_channel_divider_source_sync import cds_pkg::*;;
    // ****
    // Signals
    // ****
    logic clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic vco_a_edge, vco_b_edge, int_edge, ref_clk, ref_lost, cal_done;
    logic group0_out, group1_out, group2_out, pair_eight_nine_out, driver_ten_out;
    logic feedback_out, int_loop_pd, pre;
    logic [7:0] va, fr, in, mk;
    logic [5:0] es;
    int errors, cmp_count, cnt;

    cds_top u_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .vco_a_edge(vco_a_edge), .vco_b_edge(vco_b_edge), .int_edge(int_edge),
        .ref_clk(ref_clk), .ref_lost(ref_lost), .cal_done(cal_done),
        .group0_out(group0_out), .group1_out(group1_out), .group2_out(group2_out),
        .pair_eight_nine_out(pair_eight_nine_out), .driver_ten_out(driver_ten_out),
        .feedback_out(feedback_out), .int_loop_pd(int_loop_pd));

    // ****
    // Tasks and expectations
    // ****
    task automatic close_out;
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdv(input logic [11:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk_val(r, {24'h0, e});
    endtask

    function automatic logic exp_pd(input logic [2:0] c);
        return !((!c[0] && !c[1]) || !c[2]);
    endfunction

    // Sources: group1 from b, group2 from a, group3 from int_loop
    function automatic logic [5:0] exp_sync(input logic [7:0] f, v, i, m);
        logic a, b;
        a = v[2] | f[2];
        b = v[6] | f[2];
        return {a & ~m[4], i[2], i[2], a & ~m[2], b & ~m[5], a & ~m[0]};
    endfunction

    // ****
    // Clock, sources and watchdog
    // ****
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        vco_a_edge <= 1'($urandom);
        vco_b_edge <= 1'($urandom);
        int_edge <= 1'($urandom);
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out;
    end

    // ****
    // Main sequence
    // ****
    initial begin
        {resetn, hsel, hwrite, htrans, haddr, hwdata, cal_done, ref_clk, ref_lost} = '0;
        {vco_a_edge, vco_b_edge, int_edge} = '0;
        hsize = 3'h2;
        errors = 0;
        cmp_count = 0;
        void'($urandom(32'h3DE0));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            rdv(IDX_RATIO[12*k +: 12], (k == 5) ? RATIO_FB_RST : RATIO_RST);
        end
        rdv(IDX_MASK, CTL_RST);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk_val(r[8:7], 32'h2);
        chk_bit(int_loop_pd, 1'b0);
        wr(12'h0AA, 8'h5A);
        rdv(12'h0AA, 8'h00);
        for (int k = 0; k < 6; k++) begin
            va = 8'($urandom);
            wr(IDX_PHASE[12*k +: 12], va);
            rdv(IDX_PHASE[12*k +: 12], va);
        end
        for (int c = 0; c < 8; c++) begin
            pre = int_loop_pd;
            wr(12'h241, {c[0], c[1], 6'h00});
            wr(12'h245, {1'b0, c[2], 6'h00});
            bus(1'b0, IDX_STATUS, 8'h00);
            chk_bit(int_loop_pd, pre);
            wr(IDX_IOUPD, IOUPD_GO);
            bus(1'b0, IDX_STATUS, 8'h00);
            chk_bit(int_loop_pd, exp_pd(3'(c)));
            chk_bit(r[7], exp_pd(3'(c)));
        end
        for (int v = 0; v < 4; v++) begin
            ref_clk <= v[0];
            ref_lost <= v[1];
            bus(1'b0, IDX_STATUS, 8'h00);
            chk_bit(driver_ten_out, v[0] & ~v[1]);
            chk_bit(pair_eight_nine_out, v[0] & ~v[1]);
            chk_bit(r[6], v[1]);
        end
        ref_lost <= 1'b0;
        wr(12'h241, 8'h00);
        wr(12'h245, 8'h00);
        wr(12'h147, 8'h40);
        wr(12'h14B, 8'h00);
        for (int i = 0; i < 12; i++) begin
            va = 8'($urandom) & 8'h44;
            fr = 8'($urandom) & 8'h04;
            in = 8'($urandom) & 8'h04;
            mk = 8'($urandom) & 8'h7F;
            wr(IDX_VCO, va);
            wr(IDX_FRAC, fr);
            wr(IDX_INT, in);
            wr(IDX_MASK, mk);
            wr(IDX_IOUPD, IOUPD_GO);
            bus(1'b0, IDX_STATUS, 8'h00);
            es = exp_sync(fr, va, in, mk);
            chk_val(r[5:0], es);
            chk_bit(group0_out & es[0], 1'b0);
            chk_bit(group1_out & es[1], 1'b0);
            chk_bit(group2_out & es[2], 1'b0);
            chk_bit(pair_eight_nine_out & es[3], 1'b0);
            chk_bit(driver_ten_out & es[4], 1'b0);
            chk_bit(feedback_out & es[5], 1'b0);
        end
        wr(IDX_VCO, 8'h00);
        wr(IDX_FRAC, 8'h00);
        wr(IDX_INT, 8'h00);
        wr(12'h140, 8'h01);
        wr(12'h141, 8'h00);
        wr(IDX_IOUPD, IOUPD_GO);
        cnt = 0;
        repeat (40) begin
            pre = group0_out;
            @(posedge clk);
            if (group0_out === 1'b1 && pre === 1'b0) cnt++;
        end
        chk_bit(cnt > 0, 1'b1);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        bus(1'b0, IDX_STATUS, 8'h00);
        chk_bit(r[8], 1'b0);
        wr(IDX_FRAC, 8'h01);
        wr(IDX_IOUPD, IOUPD_GO);
        wr(IDX_FRAC, 8'h00);
        wr(IDX_IOUPD, IOUPD_GO);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk_bit(r[8], 1'b1);
        close_out;
    end
endmodule
`default_nettype wire
